// ==== epif_frame.sv ====
// external pin interrupt frame: registers, edge detect and requests
// What this block does
// - decode sixteen-byte frame of control/flag pairs
// - first pair is always type A
// - further pin pairs grow upward contiguously
// - power fault pairs grow downward from top
// - reset makes every pin a digital input
// - type A: nmi, maskable or input only
// - type A direction always reads as input
// - type C never raises a nonmaskable interrupt
// - level bit returns present pin level
// - nmi select routes edge to nonmaskable
// - edge select: one rising, zero falling
// - level select high/low priority, ignored under nmi
// - enable gates maskable request, ignored under nmi
// - type A control bit positions fixed
// - type A bits four, three reserved
// - bit seven of control byte reserved
// - flag lives in byte after control
// - freeze options may fix type A nmi/edge
// - flag sets on every selected edge, software clears
// - one request per edge; clear cancels pending
// - type B/C direction selects input or output while nmi and enable are clear
// - output value sets driven level
`timescale 1ns/1ps
module epif_frame
  import epif_pkg::*;
#(
  parameter int NUM_PINS = 3,
  parameter int NUM_PM = 2,
  // two bits per pin, lsb first, pin 0 must be type A (A, B, C here)
  parameter logic [15:0] PIN_TYPES = 16'h0024,
  // freeze enables and frozen values, one bit per pin
  parameter logic [7:0] FREEZE_NMI_EN = 8'h00,
  parameter logic [7:0] FREEZE_NMI_VAL = 8'h00,
  parameter logic [7:0] FREEZE_EDGE_EN = 8'h00,
  parameter logic [7:0] FREEZE_EDGE_VAL = 8'h00
)(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  input wire logic [7*NUM_PM-1:0] pm_fault,
  output logic nmi_req,
  output logic irq_high_req,
  output logic irq_low_req,
  output logic [NUM_PM-1:0] pm_irq_req
);

  // refuse frames that do not fit sixteen bytes
  initial
  begin
    if (NUM_PINS < 1 || NUM_PINS > EPIF_MAX_PINS || NUM_PM < 1
        || NUM_PINS + NUM_PM > 8 || PIN_TYPES[1:0] != EPIF_TYPE_A)
      $error("epif_frame: bad frame layout");
  end

  // whole module state
  typedef struct packed {
    epif_pin_ctrl_t [NUM_PINS-1:0] ctrl; // control fields per pin
    logic [NUM_PINS-1:0] flag;      // sticky edge flags
    logic [NUM_PINS-1:0] sync1;     // first synchroniser stage
    logic [NUM_PINS-1:0] sync2;     // second synchroniser stage
    logic [NUM_PINS-1:0] prev;      // last synchronised level
    logic [NUM_PINS-1:0] pend_nmi;  // nmi pending per pin
    logic [NUM_PINS-1:0] pend_irq;  // maskable pending per pin
    logic [NUM_PM-1:0][7:0] pm_en;   // power fault enable bytes
    logic [NUM_PM-1:0][7:0] pm_flag; // power fault flag bytes
    logic [7:0] rdata;              // read data register
    logic [NUM_PINS-1:0] pout;      // pin output drive
    logic [NUM_PINS-1:0] poe;       // pin output enable
    logic nmi;                      // nmi request output
    logic irq_hi;                   // high level request output
    logic irq_lo;                   // low level request output
    logic [NUM_PM-1:0] pm_irq;      // power fault group requests
  } epif_state_t;

  epif_state_t st;      // registered state
  epif_state_t next_st; // next state
  epif_bus_req_t req;   // grouped bus request

  assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  // effective per-pin fields after type and freeze
  logic [NUM_PINS-1:0] eff_nmi;
  logic [NUM_PINS-1:0] eff_dir;
  logic [NUM_PINS-1:0] eff_edge;

  // type and freeze overrides
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      eff_dir[i] = (PIN_TYPES[2*i +: 2] == EPIF_TYPE_A) ? 1'b0
                   : st.ctrl[i].dir;
      eff_nmi[i] = (PIN_TYPES[2*i +: 2] == EPIF_TYPE_C) ? 1'b0
                   : st.ctrl[i].nmi;
      eff_edge[i] = st.ctrl[i].edge_rise;
      if (PIN_TYPES[2*i +: 2] == EPIF_TYPE_A)
      begin
        if (FREEZE_NMI_EN[i])
          eff_nmi[i] = FREEZE_NMI_VAL[i];
        if (FREEZE_EDGE_EN[i])
          eff_edge[i] = FREEZE_EDGE_VAL[i];
      end
    end
  end

  // next state logic
  always_comb
  begin
    logic [3:0] off;
    logic in_frame;
    logic hit_pin;
    logic hit_pm;
    logic is_flag;
    int pidx;
    int midx;
    logic edge_ev;
    logic clr;
    logic [7:0] rd;
    logic [NUM_PINS-1:0] clr_vec; // flag clears seen this cycle
    edge_ev = 1'b0;
    clr = 1'b0;
    clr_vec = '0;
    next_st = st;
    off = req.addr[3:0];
    in_frame = (req.addr[7:4] == EPIF_FRAME_BASE[7:4]);
    is_flag = off[0];
    pidx = int'(off[3:1]);
    hit_pin = in_frame && (pidx < NUM_PINS);
    midx = 7 - int'(off[3:1]);
    hit_pm = in_frame && !hit_pin && (midx < NUM_PM);
    rd = 8'h00;
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      edge_ev = eff_edge[i] ? (st.sync2[i] && !st.prev[i])
                            : (!st.sync2[i] && st.prev[i]);
      clr = req.wr && hit_pin && is_flag && (pidx == i)
            && !req.wdata[EPIF_BIT_FLAG];
      clr_vec[i] = clr;
      next_st.flag[i] = edge_ev | (st.flag[i] & ~clr);
      next_st.pend_nmi[i] = edge_ev && eff_nmi[i];
      next_st.pend_irq[i] = edge_ev && !eff_nmi[i] && st.ctrl[i].en;
      if (clr && !edge_ev)
      begin
        next_st.pend_nmi[i] = 1'b0;
        next_st.pend_irq[i] = 1'b0;
      end
      // digital output drive, type A never drives
      next_st.poe[i] = !eff_nmi[i] && !st.ctrl[i].en && eff_dir[i];
      next_st.pout[i] = next_st.poe[i] && st.ctrl[i].dout;
    end
    // control byte writes
    if (req.wr && hit_pin && !is_flag)
    begin
      next_st.ctrl[pidx].nmi = req.wdata[EPIF_BIT_NMI];
      next_st.ctrl[pidx].edge_rise = req.wdata[EPIF_BIT_EDGE];
      next_st.ctrl[pidx].prio_low = req.wdata[EPIF_BIT_PRIO];
      next_st.ctrl[pidx].en = req.wdata[EPIF_BIT_EN];
      if (PIN_TYPES[2*pidx +: 2] != EPIF_TYPE_A)
      begin
        next_st.ctrl[pidx].dir = req.wdata[EPIF_BIT_DIR];
        next_st.ctrl[pidx].dout = req.wdata[EPIF_BIT_OUT];
      end
    end
    // power fault flags set from sources, group bit when any set
    for (int m = 0; m < NUM_PM; m++)
    begin
      for (int b = 0; b < 7; b++)
      begin
        clr = req.wr && hit_pm && is_flag && (midx == m) && !req.wdata[b];
        next_st.pm_flag[m][b] = (pm_fault[7*m+b] & st.pm_en[m][b])
                                | (st.pm_flag[m][b] & ~clr);
      end
      next_st.pm_flag[m][7] = |next_st.pm_flag[m][6:0];
      next_st.pm_irq[m] = st.pm_en[m][7] && st.pm_flag[m][7];
      if (req.wr && hit_pm && !is_flag && midx == m)
        next_st.pm_en[m] = req.wdata;
    end
    // combine pin requests
    // a clear also drops a request already in flight
    next_st.nmi = |(st.pend_nmi & ~clr_vec);
    next_st.irq_hi = 1'b0;
    next_st.irq_lo = 1'b0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (st.pend_irq[i] && !clr_vec[i] && !st.ctrl[i].prio_low)
        next_st.irq_hi = 1'b1;
      if (st.pend_irq[i] && !clr_vec[i] && st.ctrl[i].prio_low)
        next_st.irq_lo = 1'b1;
    end
    // read path, data one cycle later
    if (req.rd && hit_pin)
    begin
      if (is_flag)
        rd[EPIF_BIT_FLAG] = st.flag[pidx];
      else
      begin
        rd[EPIF_BIT_LEVEL] = st.sync2[pidx];
        rd[EPIF_BIT_NMI] = eff_nmi[pidx];
        rd[EPIF_BIT_DIR] = eff_dir[pidx];
        rd[EPIF_BIT_OUT] = (PIN_TYPES[2*pidx +: 2] == EPIF_TYPE_A) ? 1'b0
                           : st.ctrl[pidx].dout;
        rd[EPIF_BIT_EDGE] = eff_edge[pidx];
        rd[EPIF_BIT_PRIO] = st.ctrl[pidx].prio_low;
        rd[EPIF_BIT_EN] = st.ctrl[pidx].en;
      end
    end
    else if (req.rd && hit_pm)
      rd = is_flag ? st.pm_flag[midx] : st.pm_en[midx];
    next_st.rdata = rd;
  end

  // register the state
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      // every pin back to digital input
      for (int i = 0; i < NUM_PINS; i++)
        st.ctrl[i] <= EPIF_CTRL_RESET[5:0];
      st.flag <= '0;
      st.sync1 <= '0;
      st.sync2 <= '0;
      st.prev <= '0;
      st.pend_nmi <= '0;
      st.pend_irq <= '0;
      for (int m = 0; m < NUM_PM; m++)
      begin
        st.pm_en[m] <= EPIF_PM_RESET;
        st.pm_flag[m] <= EPIF_PM_RESET;
      end
      st.rdata <= 8'h00;
      st.pout <= '0;
      st.poe <= '0;
      st.nmi <= 1'b0;
      st.irq_hi <= 1'b0;
      st.irq_lo <= 1'b0;
      st.pm_irq <= '0;
    end
    else
      st <= next_st;
  end

  // outputs straight from flops
  assign bus_rdata = st.rdata;
  assign pin_out = st.pout;
  assign pin_oe = st.poe;
  assign nmi_req = st.nmi;
  assign irq_high_req = st.irq_hi;
  assign irq_low_req = st.irq_lo;
  assign pm_irq_req = st.pm_irq;

endmodule : epif_frame

// ==== epif_pkg.sv ====
// package for the external pin interrupt frame
package epif_pkg;

  // frame decode: byte address bits [3:0] inside the 16-byte frame
  localparam logic [7:0] EPIF_FRAME_BASE = 8'h70;
  localparam logic [3:0] EPIF_FRAME_MASK_HI = 4'h7;
  localparam int EPIF_MAX_PINS = 8;
  localparam int EPIF_MAX_PM = 7;

  // printed offsets of the populated example bytes
  localparam logic [7:0] EPIF_PIN_IRQ1_CONTROL = 8'h70;
  localparam logic [7:0] EPIF_PIN_IRQ1_FLAG = 8'h71;
  localparam logic [7:0] EPIF_PIN_IRQ2_CONTROL = 8'h72;
  localparam logic [7:0] EPIF_PIN_IRQ2_FLAG = 8'h73;
  localparam logic [7:0] EPIF_PIN_IRQ3_CONTROL = 8'h74;
  localparam logic [7:0] EPIF_PIN_IRQ3_FLAG = 8'h75;
  localparam logic [7:0] EPIF_POWER_FAULT2_ENABLE = 8'h7C;
  localparam logic [7:0] EPIF_POWER_FAULT2_FLAGS = 8'h7D;
  localparam logic [7:0] EPIF_POWER_FAULT1_ENABLE = 8'h7E;
  localparam logic [7:0] EPIF_POWER_FAULT1_FLAGS = 8'h7F;

  // control byte field positions
  localparam int EPIF_BIT_LEVEL = 6;
  localparam int EPIF_BIT_NMI = 5;
  localparam int EPIF_BIT_DIR = 4;
  localparam int EPIF_BIT_OUT = 3;
  localparam int EPIF_BIT_EDGE = 2;
  localparam int EPIF_BIT_PRIO = 1;
  localparam int EPIF_BIT_EN = 0;
  // flag byte field position
  localparam int EPIF_BIT_FLAG = 7;

  // reset values
  localparam logic [7:0] EPIF_CTRL_RESET = 8'h00;
  localparam logic [7:0] EPIF_PM_RESET = 8'h00;

  // pin types, two-bit codes
  localparam logic [1:0] EPIF_TYPE_A = 2'h0;
  localparam logic [1:0] EPIF_TYPE_B = 2'h1;
  localparam logic [1:0] EPIF_TYPE_C = 2'h2;

  // bus request carried together
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } epif_bus_req_t;

  // per-pin stored control
  typedef struct packed {
    logic nmi;
    logic dir;
    logic dout;
    logic edge_rise;
    logic prio_low;
    logic en;
  } epif_pin_ctrl_t;

endpackage : epif_pkg

// ==== epif_props.sv ====
// checker for the external pin interrupt frame
`timescale 1ns/1ps
module epif_props
  import epif_pkg::*;
#(
  parameter int NUM_PINS = 3
)(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic nmi_req,
  input wire logic irq_low_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  rd_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data without a read");
  type_a_in_a: assert property (!pin_oe[0])
    else $error("first pin driven");
  nmi_pulse_a: assert property (nmi_req |=> !nmi_req)
    else $error("nmi request too long");
  unmapped_zero_a: assert property (bus_rd && (bus_addr < 8'h70 ||
    bus_addr inside {[8'h76:8'h7B]}) |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  ctrl_rsvd_a: assert property (bus_rd && bus_addr inside
    {8'h70, 8'h72, 8'h74} |=> !bus_rdata[7])
    else $error("control bit seven set");
  type_a_rsvd_a: assert property (bus_rd && bus_addr == 8'h70
    |=> bus_rdata[4:3] == 2'h0)
    else $error("first control bits four three set");
  flag_rsvd_a: assert property (bus_rd && bus_addr inside
    {8'h71, 8'h73, 8'h75} |=> bus_rdata[6:0] == 7'h00)
    else $error("flag byte low bits set");
  oe_cause_a: assert property ($rose(pin_oe[1]) |-> $past(bus_wr, 2))
    else $error("drive began without a write");
  reset_quiet_a: assert property ($fell(reset) |-> pin_oe == '0
    && !nmi_req && !irq_low_req)
    else $error("outputs active after reset");
  nmi_seen_c: cover property (nmi_req);
  low_seen_c: cover property (irq_low_req);
  drive_seen_c: cover property ($rose(pin_oe[1]));
endmodule : epif_props
bind epif_frame epif_props #(.NUM_PINS(NUM_PINS)) props_i (.*);

// ==== epif_pins.sv ====
// model of the board around the external interrupt pins
`timescale 1ns/1ps
module epif_pins (
  input wire logic [2:0] ext_lvl,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  output logic [2:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : epif_pins

// ==== test_external_pin_interrupt_frame.sv ====
// self-checking bench for the external pin interrupt frame
`timescale 1ns/1ps
module test_external_pin_interrupt_frame;
  import epif_pkg::*;
  logic clk_sys = 0;
  logic reset = 1;
  logic [7:0] bus_addr = 0, bus_wdata = 0, bus_rdata, r;
  logic bus_wr = 0, bus_rd = 0, rd_seen = 0, nmi_req;
  logic irq_high_req, irq_low_req;
  logic [2:0] ext_lvl = 0, pin_in, pin_out, pin_oe;
  logic [13:0] pm_fault = 0;
  logic [1:0] pm_irq_req;
  logic [7:0] rd_q[$];
  logic [2:0] ev_q[$];
  logic [7:0] mask[3] = '{8'h27, 8'h2F, 8'h0F};
  int err_total = 0, checks_done = 0;
  logic [31:0] seed = 32'ha59963c1;
  always #20 clk_sys = ~clk_sys;
  epif_frame #(.PIN_TYPES(16'h0024)) dut (.clk_sys(clk_sys),
    .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pm_fault(pm_fault), .nmi_req(nmi_req), .irq_high_req(irq_high_req),
    .irq_low_req(irq_low_req), .pm_irq_req(pm_irq_req));
  epif_pins pins (.ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));
  // compare and count
  task chk(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one-cycle write strobe
  task wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1;
    @(posedge clk_sys);
    bus_wr <= 0;
  endtask : wr
  // one-cycle read strobe, expected data noted
  task rd(input logic [7:0] a, exp);
    rd_q.push_back(exp);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1;
    @(posedge clk_sys);
    bus_rd <= 0;
  endtask : rd
  // move the pins, note expected request code
  task pin(input logic [2:0] lvl, ev);
    if (ev != 0) ev_q.push_back(ev);
    @(posedge clk_sys);
    ext_lvl <= lvl;
    repeat (10) @(posedge clk_sys);
  endtask : pin
  // verdict
  task end_sim;
    chk("leftover requests", ev_q.size(), 0);
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // watcher: read data and request pulses
  always @(posedge clk_sys)
  begin
    if (rd_seen) chk("rdata", bus_rdata, rd_q.pop_front());
    if (nmi_req | irq_high_req | irq_low_req)
      chk("req", {nmi_req, irq_high_req, irq_low_req}, ev_q.pop_front());
    rd_seen <= bus_rd;
  end
  // watchdog
  initial
  begin
    #400000;
    err_total++;
    end_sim;
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 0;
    for (int a = 8'h70; a < 8'h80; a++) rd(a[7:0], 8'h00);
    for (int a = 8'h76; a < 8'h7C; a++)
    begin
      wr(a[7:0], $random(seed));
      rd(a[7:0], 8'h00);
    end
    for (int n = 0; n < 12; n++)
    begin
      r = $random(seed) & 8'hEF;
      wr(8'h70 + 8'(2 * (n % 3)), r);
      rd(8'h70 + 8'(2 * (n % 3)), r & mask[n % 3]);
      wr(8'h71 + 8'(2 * (n % 3)), 8'hFF);
      rd(8'h71 + 8'(2 * (n % 3)), 8'h00);
    end
    wr(8'h70, 8'h24);
    pin(3'b001, 3'b100);
    pin(3'b000, 3'b000);
    pin(3'b001, 3'b100);
    rd(8'h71, 8'h80);
    rd(8'h70, 8'h64);
    wr(8'h71, 8'h00);
    rd(8'h71, 8'h00);
    wr(8'h70, 8'h20);
    pin(3'b000, 3'b100);
    wr(8'h72, 8'h07);
    pin(3'b010, 3'b001);
    wr(8'h74, 8'h25);
    pin(3'b110, 3'b010);
    wr(8'h75, 8'h00);
    wr(8'h74, 8'h00);
    pin(3'b010, 3'b000);
    rd(8'h75, 8'h80);
    pin(3'b000, 3'b000);
    wr(8'h72, 8'h18);
    repeat (6) @(posedge clk_sys);
    chk("pin_oe", pin_oe, 3'b010);
    chk("pin_out", pin_out, 3'b010);
    rd(8'h72, 8'h58);
    wr(8'h7E, 8'h81);
    wr(8'h7C, 8'h82);
    pm_fault <= 14'h0101;
    repeat (4) @(posedge clk_sys);
    rd(8'h7F, 8'h81);
    rd(8'h7D, 8'h82);
    chk("pm_irq_req", pm_irq_req, 2'b11);
    repeat (4) @(posedge clk_sys);
    end_sim;
  end
endmodule : test_external_pin_interrupt_frame
